// [core/lrc_regs.sv]
// register bank and drive outputs for three linear regulators
`timescale 1ns/1ps
`include "lrc_params.svh"

module lrc_regs import lrc_pkg::*; (
	input  wire logic          mclk_in,        // 100 MHz clock
	input  wire logic          rst_in,         // async reset, active high
	input  wire logic [7:0]    reg_addr_in,    // register address
	input  wire logic [7:0]    reg_wdata_in,   // write data
	input  wire logic          reg_wr_in,      // write strobe
	input  wire logic          reg_rd_in,      // read strobe
	output logic      [7:0]    reg_rdata_out,  // read data
	output logic               reg_ack_out,    // access done pulse
	input  wire logic          otp_load_in,    // sequencer default load
	input  wire logic [4:0]    otp_one_volt_in,   // default code, one
	input  wire logic [3:0]    otp_two_volt_in,   // default code, two
	input  wire logic [4:0]    otp_three_volt_in, // default code, three
	input  wire logic [2:0]    otp_enable_in,     // default enables
	input  wire logic [2:0]    otp_standby_in,    // default standby enables
	input  wire logic [1:0]    otp_load_switch_default_in, // one, three
	input  wire lrc_pwr_mode_t mode_in,        // device operating mode
	output logic      [4:0]    reg_one_voltage_code_out,   // code, one
	output logic      [3:0]    reg_two_voltage_code_out,   // code, two
	output logic      [4:0]    reg_three_voltage_code_out, // code, three
	output logic      [2:0]    reg_on_out,        // regulator on
	output logic      [2:0]    reg_low_power_out, // low-power operation
	output logic      [1:0]    reg_load_switch_out // one, three as switch
);

	logic [4:0] volt_q  [3];
	logic [7:0] ctrl_q  [3];
	logic [4:0] otp_v   [3];
	logic [2:0] ls_q;
	logic [2:0] ls_otp;
	logic [2:0] volt_hit;
	logic [2:0] ctrl_hit;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       ack_ff, nxt_ack;

	assign otp_v[0] = otp_one_volt_in;
	assign otp_v[1] = {1'b0, otp_two_volt_in};
	assign otp_v[2] = otp_three_volt_in;
	assign ls_otp   = {otp_load_switch_default_in[1], 1'b0,
		otp_load_switch_default_in[0]};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_chan
			localparam logic [7:0] VA = (g == 0) ? `LRC_ONE_VOLT_ADDR :
				(g == 1) ? `LRC_TWO_VOLT_ADDR : `LRC_THREE_VOLT_ADDR;
			localparam logic [7:0] CA = (g == 0) ? `LRC_ONE_CTRL_ADDR :
				(g == 1) ? `LRC_TWO_CTRL_ADDR : `LRC_THREE_CTRL_ADDR;
			localparam int VW = (g == 1) ? `LRC_TWO_VOLT_W : `LRC_ONE_VOLT_W;
			assign volt_hit[g] = (reg_addr_in == VA);
			assign ctrl_hit[g] = (reg_addr_in == CA);
			lrc_chan #(
				.VOLT_W (VW),
				.HAS_LS (g != 1)
			) u_chan (
				.mclk_in         (mclk_in),
				.rst_in          (rst_in),
				.otp_load_in     (otp_load_in),
				.otp_volt_in     (otp_v[g]),
				.otp_en_in       (otp_enable_in[g]),
				.otp_stby_in     (otp_standby_in[g]),
				.otp_ls_in       (ls_otp[g]),
				.volt_wr_in      (reg_wr_in & volt_hit[g]),
				.ctrl_wr_in      (reg_wr_in & ctrl_hit[g]),
				.wdata_in        (reg_wdata_in),
				.mode_in         (mode_in),
				.volt_out        (volt_q[g]),
				.ctrl_out        (ctrl_q[g]),
				.on_out          (reg_on_out[g]),
				.low_power_out   (reg_low_power_out[g]),
				.load_switch_out (ls_q[g])
			);
		end
	endgenerate

	// unmapped addresses read as zero and writes to them are dropped
	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_ack   = reg_rd_in | reg_wr_in;
		if (reg_rd_in) begin
			nxt_rdata = `LRC_RDATA_RESET;
			for (int i = 0; i < 3; i++) begin
				if (volt_hit[i]) begin
					nxt_rdata = {3'h0, volt_q[i]};
				end
				if (ctrl_hit[i]) begin
					nxt_rdata = ctrl_q[i];
				end
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_ff <= `LRC_RDATA_RESET;
			ack_ff   <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			ack_ff   <= nxt_ack;
		end
	end

	assign reg_rdata_out              = rdata_ff;
	assign reg_ack_out                = ack_ff;
	assign reg_one_voltage_code_out   = volt_q[0];
	assign reg_two_voltage_code_out   = volt_q[1][3:0];
	assign reg_three_voltage_code_out = volt_q[2];
	assign reg_load_switch_out        = {ls_q[2], ls_q[0]};

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	logic wr_c1, wr_c2, wr_c3, wr_v1, wr_v2, wr_v3;
	assign wr_c1 = reg_wr_in & ctrl_hit[0] & ~otp_load_in;
	assign wr_c2 = reg_wr_in & ctrl_hit[1] & ~otp_load_in;
	assign wr_c3 = reg_wr_in & ctrl_hit[2] & ~otp_load_in;
	assign wr_v1 = reg_wr_in & volt_hit[0] & ~otp_load_in;
	assign wr_v2 = reg_wr_in & volt_hit[1] & ~otp_load_in;
	assign wr_v3 = reg_wr_in & volt_hit[2] & ~otp_load_in;

	a_volt_one_write: assert property (
		wr_v1 |=> reg_one_voltage_code_out == $past(reg_wdata_in[4:0]))
		else $error("regulator one code not written");
	a_volt_two_width: assert property (
		volt_q[1][4] == 1'b0)
		else $error("regulator two code wider than four bits");
	a_volt_three_write: assert property (
		wr_v3 |=> reg_three_voltage_code_out == $past(reg_wdata_in[4:0]))
		else $error("regulator three code not written");
	a_enable_off_run: assert property (
		wr_c1 && !reg_wdata_in[0] ##1 mode_in == LRC_MODE_RUN
		|=> !reg_on_out[0])
		else $error("cleared enable left regulator on");
	a_standby_off: assert property (
		mode_in == LRC_MODE_STBY && !ctrl_q[2][1] |=> !reg_on_out[2])
		else $error("regulator on in standby without standby enable");
	a_sleep_on: assert property (
		mode_in == LRC_MODE_SLEEP && ctrl_q[2][0] && ctrl_q[2][2]
		|=> reg_on_out[2])
		else $error("regulator off in sleep with sleep enable");
	a_low_power_sel: assert property (
		mode_in != LRC_MODE_RUN && ctrl_q[1][3] |=> reg_low_power_out[1])
		else $error("low-power select ignored outside run");
	a_ls_write_set: assert property (
		wr_c3 && reg_wdata_in[4] |=> reg_load_switch_out[1] [*2])
		else $error("load-switch bit not set by write");
	a_ls_no_clear: assert property (
		$fell(reg_load_switch_out[0]) |-> $past(otp_load_in))
		else $error("load-switch bit cleared by host");
	a_ls_no_lp: assert property (
		reg_load_switch_out[0] ##1 reg_load_switch_out[0]
		|-> !reg_low_power_out[0])
		else $error("load switch put in low-power mode");
	a_upper_zero: assert property (
		reg_rd_in && (ctrl_hit[0] || volt_hit[1])
		|=> reg_rdata_out[7:5] == 3'h0 && reg_ack_out)
		else $error("unused bits read as one");
	a_unused_two_ls: assert property (
		wr_c2 |=> ctrl_q[1][7:4] == 4'h0)
		else $error("unused control bits of regulator two stored");
	a_volt_two_write: assert property (
		wr_v2 |=> reg_two_voltage_code_out == $past(reg_wdata_in[3:0]))
		else $error("regulator two code not written");

	// the sequencer load must land whole, whatever the host did that cycle
	a_otp_one_volt: assert property (
		otp_load_in
		|=> reg_one_voltage_code_out == $past(otp_one_volt_in))
		else $error("regulator one default code not loaded");
	a_otp_two_volt: assert property (
		otp_load_in
		|=> reg_two_voltage_code_out == $past(otp_two_volt_in))
		else $error("regulator two default code not loaded");
	a_otp_three_volt: assert property (
		otp_load_in
		|=> reg_three_voltage_code_out == $past(otp_three_volt_in))
		else $error("regulator three default code not loaded");
	a_otp_ls_load: assert property (
		otp_load_in
		|=> reg_load_switch_out == $past(otp_load_switch_default_in))
		else $error("load-switch default not loaded");
	a_otp_sleep_clear: assert property (
		otp_load_in
		|=> !ctrl_q[0][2] && !ctrl_q[1][2] && !ctrl_q[2][2])
		else $error("sleep enable not cleared by default load");
	a_enable_run_on: assert property (
		mode_in == LRC_MODE_RUN && ctrl_q[0][0] |=> reg_on_out[0])
		else $error("enabled regulator off in run");
	a_run_full_power: assert property (
		mode_in == LRC_MODE_RUN |=> reg_low_power_out == 3'h0)
		else $error("low-power operation in run");
	a_ls_three_no_lp: assert property (
		reg_load_switch_out[1] ##1 reg_load_switch_out[1]
		|-> !reg_low_power_out[2])
		else $error("regulator three switch put in low-power mode");

	// ack is the only sign of completion, so it must track every strobe
	a_ack_after_req: assert property (
		reg_rd_in || reg_wr_in |=> reg_ack_out)
		else $error("access not acknowledged");
	a_no_ack_idle: assert property (
		!reg_rd_in && !reg_wr_in |=> !reg_ack_out)
		else $error("acknowledge without access");
	a_rdata_hold: assert property (
		!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data changed without a read");

	c_ls_set: cover property (wr_c1 && reg_wdata_in[4] ##1 ls_q[0]);
	c_standby: cover property (mode_in == LRC_MODE_STBY && reg_on_out[0]);
	c_sleep_lp: cover property (mode_in == LRC_MODE_SLEEP
		##1 reg_low_power_out[2]);
	c_read_ack: cover property (reg_rd_in ##1 reg_ack_out);
	c_load_wins: cover property (otp_load_in && reg_wr_in);

endmodule

// [inc/lrc_params.svh]
// offsets, field positions and widths of the linear regulator control registers
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH

`define LRC_ADDR_W          8
`define LRC_DATA_W          8
`define LRC_ONE_VOLT_ADDR   8'h4C
`define LRC_ONE_CTRL_ADDR   8'h4D
`define LRC_TWO_VOLT_ADDR   8'h4F
`define LRC_TWO_CTRL_ADDR   8'h50
`define LRC_THREE_VOLT_ADDR 8'h52
`define LRC_THREE_CTRL_ADDR 8'h53

`define LRC_VOLT_FIELD_W    5
`define LRC_ONE_VOLT_W      5
`define LRC_TWO_VOLT_W      4
`define LRC_THREE_VOLT_W    5

`define LRC_EN_BIT          0
`define LRC_STBY_BIT        1
`define LRC_SLEEP_BIT       2
`define LRC_LPWR_BIT        3
`define LRC_LS_BIT          4

`define LRC_VOLT_RESET      5'h00
`define LRC_CTRL_RESET      1'b0
`define LRC_RDATA_RESET     8'h00

`endif

// [inc/lrc_pkg.sv]
// types shared by the linear regulator control register bank
package lrc_pkg;

	// operating mode reported by the device state machine
	typedef enum logic [1:0] {
		LRC_MODE_RUN   = 2'b00,
		LRC_MODE_STBY  = 2'b01,
		LRC_MODE_SLEEP = 2'b11
	} lrc_pwr_mode_t;

endpackage

// [core/lrc_chan.sv]
// one linear regulator: voltage code, control bits and drive outputs
`timescale 1ns/1ps
`include "lrc_params.svh"

module lrc_chan import lrc_pkg::*; #(
	parameter int VOLT_W = 5,
	parameter bit HAS_LS = 1'b1
) (
	input  wire logic          mclk_in,     // system clock
	input  wire logic          rst_in,      // async reset, active high
	input  wire logic          otp_load_in, // power-up default load pulse
	input  wire logic [4:0]    otp_volt_in, // default voltage code
	input  wire logic          otp_en_in,   // default enable
	input  wire logic          otp_stby_in, // default standby enable
	input  wire logic          otp_ls_in,   // default load-switch select
	input  wire logic          volt_wr_in,  // write voltage register
	input  wire logic          ctrl_wr_in,  // write control register
	input  wire logic [7:0]    wdata_in,    // write data
	input  wire lrc_pwr_mode_t mode_in,     // operating mode
	output logic      [4:0]    volt_out,    // voltage code
	output logic      [7:0]    ctrl_out,    // control register readback
	output logic               on_out,      // regulator switched on
	output logic               low_power_out, // low-power operation
	output logic               load_switch_out // load-switch operation
);

	localparam logic [4:0] VMASK = 5'((32'd1 << VOLT_W) - 32'd1);

	logic [4:0] volt_ff, nxt_volt;
	logic       en_ff, nxt_en;
	logic       stby_ff, nxt_stby;
	logic       sleep_ff, nxt_sleep;
	logic       lpwr_ff, nxt_lpwr;
	logic       ls_ff, nxt_ls;
	logic       on_ff, nxt_on;
	logic       lp_ff, nxt_lp;

	always_comb begin
		nxt_volt  = volt_ff;
		nxt_en    = en_ff;
		nxt_stby  = stby_ff;
		nxt_sleep = sleep_ff;
		nxt_lpwr  = lpwr_ff;
		nxt_ls    = ls_ff;
		if (otp_load_in) begin
			// the sequencer load wins over a host write in the same cycle
			nxt_volt  = otp_volt_in & VMASK;
			nxt_en    = otp_en_in;
			nxt_stby  = otp_stby_in;
			nxt_sleep = `LRC_CTRL_RESET;
			nxt_lpwr  = `LRC_CTRL_RESET;
			nxt_ls    = HAS_LS & otp_ls_in;
		end else begin
			if (volt_wr_in) begin
				nxt_volt = wdata_in[4:0] & VMASK;
			end
			if (ctrl_wr_in) begin
				nxt_en    = wdata_in[`LRC_EN_BIT];
				nxt_stby  = wdata_in[`LRC_STBY_BIT];
				nxt_sleep = wdata_in[`LRC_SLEEP_BIT];
				nxt_lpwr  = wdata_in[`LRC_LPWR_BIT];
				// host may only set the load-switch bit, never clear it
				nxt_ls = ls_ff | (HAS_LS & wdata_in[`LRC_LS_BIT]);
			end
		end
		unique case (mode_in)
			LRC_MODE_RUN:   nxt_on = en_ff;
			LRC_MODE_STBY:  nxt_on = en_ff & stby_ff;
			LRC_MODE_SLEEP: nxt_on = en_ff & sleep_ff;
			default:        nxt_on = 1'b0;
		endcase
		// a load switch is fully on, so it has no low-power regulation
		nxt_lp = lpwr_ff & (mode_in != LRC_MODE_RUN) & ~ls_ff;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			volt_ff  <= `LRC_VOLT_RESET;
			en_ff    <= `LRC_CTRL_RESET;
			stby_ff  <= `LRC_CTRL_RESET;
			sleep_ff <= `LRC_CTRL_RESET;
			lpwr_ff  <= `LRC_CTRL_RESET;
			ls_ff    <= `LRC_CTRL_RESET;
			on_ff    <= `LRC_CTRL_RESET;
			lp_ff    <= `LRC_CTRL_RESET;
		end else begin
			volt_ff  <= nxt_volt;
			en_ff    <= nxt_en;
			stby_ff  <= nxt_stby;
			sleep_ff <= nxt_sleep;
			lpwr_ff  <= nxt_lpwr;
			ls_ff    <= nxt_ls;
			on_ff    <= nxt_on;
			lp_ff    <= nxt_lp;
		end
	end

	assign volt_out        = volt_ff;
	assign ctrl_out        = {3'h0, ls_ff, lpwr_ff, sleep_ff, stby_ff, en_ff};
	assign on_out          = on_ff;
	assign low_power_out   = lp_ff;
	assign load_switch_out = ls_ff;

endmodule

// [verification/lrc_host.sv]
// host model that drives the register access port of the bank
`timescale 1ns/1ps
module lrc_host (
	input  wire logic       mclk_in,   // system clock
	output logic      [7:0] addr_out,  // register address
	output logic      [7:0] wdata_out, // write data
	output logic            wr_out,    // write strobe
	output logic            rd_out,    // read strobe
	input  wire logic [7:0] rdata_in,  // read data
	input  wire logic       ack_in     // access done
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// strobe lives one cycle; ack and data are taken while they stand
	task automatic access(input logic [7:0] a, input logic [7:0] d,
		input logic w, output logic [7:0] q, output logic k);
		@(negedge mclk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(negedge mclk_in);
		q = rdata_in;
		k = ack_in;
		wr_out = 1'b0;
		rd_out = 1'b0;
		// released lines flip so a stale value can never match
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule

// [verification/tb_top.sv]
// testbench for the linear regulator control register bank
`timescale 1ns/1ps
module tb_top;
	logic                   mclk, rst, wr, rd, ack, oload;
	logic             [7:0] addr, wdata, rdata;
	logic             [4:0] ov1, ov3, v1, v3;
	logic             [3:0] ov2, v2;
	logic             [2:0] oen, ostb, on, lp;
	logic             [1:0] ols, ls;
	lrc_pkg::lrc_pwr_mode_t mode;
	int                     fail_count, checks, cyc;
	logic [1:0] mtab [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
	logic [2:0] otab [4] = '{3'b111, 3'b011, 3'b110, 3'b000};
	logic [2:0] ltab [4] = '{3'b000, 3'b010, 3'b010, 3'b010};

	lrc_host host_inst (.mclk_in(mclk), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd),
		.rdata_in(rdata), .ack_in(ack));
	lrc_regs lrc_regs_inst (.mclk_in(mclk), .rst_in(rst),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .reg_ack_out(ack),
		.otp_load_in(oload), .otp_one_volt_in(ov1),
		.otp_two_volt_in(ov2), .otp_three_volt_in(ov3),
		.otp_enable_in(oen), .otp_standby_in(ostb),
		.otp_load_switch_default_in(ols), .mode_in(mode),
		.reg_one_voltage_code_out(v1), .reg_two_voltage_code_out(v2),
		.reg_three_voltage_code_out(v3), .reg_on_out(on),
		.reg_low_power_out(lp), .reg_load_switch_out(ls));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic complete_run;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic       k;
		host_inst.access(a, 8'h00, 1'b0, q, k);
		check({7'h00, k}, 8'h01);
		check(q, e);
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       k;
		host_inst.access(a, d, 1'b1, q, k);
		check({7'h00, k}, 8'h01);
	endtask
	// drive outputs trail the control bits by one cycle
	task automatic outs(input logic [2:0] eo, input logic [2:0] el);
		repeat (2) @(negedge mclk);
		check({5'h00, on}, {5'h00, eo});
		check({5'h00, lp}, {5'h00, el});
	endtask
	task automatic otp_pulse;
		@(negedge mclk);
		oload = 1'b1;
		@(negedge mclk);
		oload = 1'b0;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 1000) begin
			fail_count++;
			complete_run;
		end
	end
	initial begin
		rst = 1'b1;
		oload = 1'b0;
		mode = lrc_pkg::LRC_MODE_RUN;
		{ov1, ov2, ov3, ols} = {5'h15, 4'hA, 5'h1F, 2'h1};
		oen = 3'h7;
		ostb = 3'h7;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		rdc(8'h4D, 8'h00);
		rdc(8'h4E, 8'h00);
		otp_pulse();
		rdc(8'h4C, 8'h15);
		rdc(8'h4F, 8'h0A);
		rdc(8'h52, 8'h1F);
		rdc(8'h4D, 8'h13);
		rdc(8'h50, 8'h03);
		rdc(8'h53, 8'h03);
		check({6'h00, ls}, 8'h01);
		check({3'h0, v3}, 8'h1F);
		wrr(8'h4C, 8'hFF);
		rdc(8'h4C, 8'h1F);
		check({3'h0, v1}, 8'h1F);
		wrr(8'h52, 8'hE7);
		rdc(8'h52, 8'h07);
		check({3'h0, v3}, 8'h07);
		wrr(8'h4F, 8'hFF);
		rdc(8'h4F, 8'h0F);
		check({4'h0, v2}, 8'h0F);
		wrr(8'h50, 8'hFF);
		rdc(8'h50, 8'h0F);
		wrr(8'h4D, 8'h00);
		rdc(8'h4D, 8'h10);
		outs(3'b110, 3'b000);
		wrr(8'h53, 8'h10);
		rdc(8'h53, 8'h10);
		check({6'h00, ls}, 8'h03);
		wrr(8'h53, 8'h00);
		rdc(8'h53, 8'h10);
		wrr(8'h4D, 8'h1B);
		wrr(8'h50, 8'h0F);
		wrr(8'h53, 8'h15);
		for (int i = 0; i < 4; i++) begin
			mode = lrc_pkg::lrc_pwr_mode_t'(mtab[i]);
			outs(otab[i], ltab[i]);
		end
		mode = lrc_pkg::LRC_MODE_RUN;
		// a write that meets the default load is lost to it
		fork
			wrr(8'h4F, 8'h05);
			otp_pulse();
		join
		rdc(8'h4F, 8'h0A);
		rdc(8'h50, 8'h03);
		rdc(8'h53, 8'h03);
		@(negedge mclk);
		rst = 1'b1;
		@(negedge mclk);
		rst = 1'b0;
		rdc(8'h4C, 8'h00);
		check({5'h00, on}, 8'h00);
		check({6'h00, ls}, 8'h00);
		complete_run;
	end
endmodule
